// >>> embedded_block_ram.sv
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module embedded_block_ram
    import block_memory_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // avalon-mm register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // port a user side
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [13:0] a_addr,
    input wire logic [35:0] a_wdata,
    input wire logic [3:0] a_byte_en,
    output logic [35:0] a_rdata,
    output logic a_rvalid,
    // port b user side
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [13:0] b_addr,
    input wire logic [35:0] b_wdata,
    input wire logic [3:0] b_byte_en,
    output logic [35:0] b_rdata,
    output logic b_rvalid
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0] control_reg, control_next;
    logic [10:0] init_addr_reg, init_addr_next;
    logic collide_reg, collide_next;
    logic ack_reg, ack_next;
    logic [31:0] readdata_reg, readdata_next;
    logic [31:0] status_word;
    logic access, wr_fire, init_wr;
    mode_t mode;
    width_t width_a, width_b;
    logic shape_error, init_mode, ports_on;
    logic a_read_allow, a_write_allow, b_read_allow, b_write_allow;
    logic [10:0] a_base, b_base;
    logic [1:0] a_lane_mask, b_lane_mask;
    logic a_arr_wr, b_arr_wr;
    logic [35:0] a_arr_wdata, a_arr_wmask, a_arr_rdata;
    logic [35:0] b_arr_wdata, b_arr_wmask, b_arr_rdata;
    logic [8:0] mem_reg [0:ENTRY_COUNT-1];
    logic [8:0] mem_next [0:ENTRY_COUNT-1];
    logic [ENTRY_COUNT-1:0] collide_vec;
    logic collide_event;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    // each port takes its width from its own field
    assign mode = mode_t'(control_reg[CTL_MODE_LSB +: MODE_FIELD_BITS]);
    assign width_a = width_t'(control_reg[CTL_WIDTH_A_LSB +: WIDTH_FIELD_BITS]);
    assign width_b = width_t'(control_reg[CTL_WIDTH_B_LSB +: WIDTH_FIELD_BITS]);
    assign init_mode = control_reg[CTL_INIT_BIT];

    // unlisted codes and 36-bit true dual-port shut both ports off
    always_comb begin
        shape_error = 1'b0;
        if (width_a > WIDTH_36 || width_b > WIDTH_36) begin
            shape_error = 1'b1;
        end
        if (mode != MODE_SINGLE && mode != MODE_TRUE_DUAL && mode != MODE_PSEUDO_DUAL) begin
            shape_error = 1'b1;
        end
        if (mode == MODE_TRUE_DUAL && (width_a == WIDTH_36 || width_b == WIDTH_36)) begin
            shape_error = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // port roles per mode
    // ------------------------------------------------------------
    // single: a only; true dual: both read/write; pseudo: a writes, b reads
    always_comb begin
        ports_on = ~init_mode & ~shape_error;
        a_read_allow = ports_on & (mode != MODE_PSEUDO_DUAL);
        a_write_allow = ports_on;
        b_read_allow = ports_on & (mode != MODE_SINGLE);
        b_write_allow = ports_on & (mode == MODE_TRUE_DUAL);
    end

    // ------------------------------------------------------------
    // user ports
    // ------------------------------------------------------------
    block_memory_port port_a (
        .core_clk(core_clk),
        .reset(reset),
        .width(width_a),
        .parity_en(control_reg[CTL_PARITY_A_BIT]),
        .out_reg_en(control_reg[CTL_OUTREG_A_BIT]),
        .read_allow(a_read_allow),
        .write_allow(a_write_allow),
        .req_en(a_en),
        .req_we(a_we),
        .req_addr(a_addr),
        .req_wdata(a_wdata),
        .req_byte_en(a_byte_en),
        .rdata(a_rdata),
        .rvalid(a_rvalid),
        .arr_base(a_base),
        .arr_lane_mask(a_lane_mask),
        .arr_wr(a_arr_wr),
        .arr_wdata(a_arr_wdata),
        .arr_wmask(a_arr_wmask),
        .arr_rdata(a_arr_rdata)
    );

    block_memory_port port_b (
        .core_clk(core_clk),
        .reset(reset),
        .width(width_b),
        .parity_en(control_reg[CTL_PARITY_B_BIT]),
        .out_reg_en(control_reg[CTL_OUTREG_B_BIT]),
        .read_allow(b_read_allow),
        .write_allow(b_write_allow),
        .req_en(b_en),
        .req_we(b_we),
        .req_addr(b_addr),
        .req_wdata(b_wdata),
        .req_byte_en(b_byte_en),
        .rdata(b_rdata),
        .rvalid(b_rvalid),
        .arr_base(b_base),
        .arr_lane_mask(b_lane_mask),
        .arr_wr(b_arr_wr),
        .arr_wdata(b_arr_wdata),
        .arr_wmask(b_arr_wmask),
        .arr_rdata(b_arr_rdata)
    );

    // ------------------------------------------------------------
    // read lanes: up to four consecutive entries per access
    // ------------------------------------------------------------
    for (genvar l = 0; l < LANE_COUNT; l++) begin : g_rd_lane
        assign a_arr_rdata[9*l +: 9] = mem_reg[a_base | 11'(l)];
        assign b_arr_rdata[9*l +: 9] = mem_reg[b_base | 11'(l)];
    end

    // ------------------------------------------------------------
    // storage array, one 9-bit entry per flip-flop group
    // ------------------------------------------------------------
    for (genvar i = 0; i < ENTRY_COUNT; i++) begin : g_entry
        localparam logic [10:0] IDX = 11'(i);
        logic hit_a, hit_b;
        logic [1:0] lane_a, lane_b;
        logic [8:0] mask_a, mask_b;

        // port a is applied last, so it wins where both write one bit
        always_comb begin
            lane_a = IDX[1:0] & a_lane_mask;
            lane_b = IDX[1:0] & b_lane_mask;
            hit_a = a_arr_wr & ((IDX & ~{9'h000, a_lane_mask}) == a_base);
            hit_b = b_arr_wr & ((IDX & ~{9'h000, b_lane_mask}) == b_base);
            mask_a = a_arr_wmask[9*lane_a +: 9];
            mask_b = b_arr_wmask[9*lane_b +: 9];
            mem_next[i] = mem_reg[i];
            if (hit_b) begin
                mem_next[i] = (mem_next[i] & ~mask_b) | (b_arr_wdata[9*lane_b +: 9] & mask_b);
            end
            if (hit_a) begin
                mem_next[i] = (mem_next[i] & ~mask_a) | (a_arr_wdata[9*lane_a +: 9] & mask_a);
            end
            if (init_wr && init_addr_reg == IDX) begin
                mem_next[i] = avs_writedata[8:0];
            end
            collide_vec[i] = hit_a & hit_b & ((mask_a & mask_b) != 9'h000);
        end

        // reset, loads and port writes fill entries; without writes it holds as a rom
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                mem_reg[i] <= INIT_FILL;
            end else begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign collide_event = |collide_vec;

    // ------------------------------------------------------------
    // avalon-mm slave: one wait cycle for every access
    // ------------------------------------------------------------
    // readdata is latched in the wait cycle so it stands at the answer edge
    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_reg;
    assign wr_fire = avs_write & ack_reg;
    assign init_wr = wr_fire & (avs_address == INIT_DATA_OFFSET) & init_mode & avs_byteenable[0];
    assign avs_readdata = readdata_reg;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_SHAPE_ERR_BIT] = shape_error;
        status_word[STAT_INIT_BIT] = init_mode;
        status_word[STAT_COLLIDE_BIT] = collide_reg;
    end

    // register writes; collision set wins over its clear
    always_comb begin
        ack_next = access & ~ack_reg;
        readdata_next = readdata_reg;
        control_next = control_reg;
        init_addr_next = init_addr_reg;
        collide_next = collide_reg;
        if (avs_read && !ack_reg) begin
            case (avs_address)
                CONTROL_OFFSET: readdata_next = control_reg;
                STATUS_OFFSET: readdata_next = status_word;
                INIT_ADDR_OFFSET: readdata_next = {21'h0, init_addr_reg};
                INIT_DATA_OFFSET: readdata_next = {23'h0, mem_reg[init_addr_reg]};
                default: readdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_fire) begin
            case (avs_address)
                CONTROL_OFFSET: begin
                    for (int k = 0; k < 4; k++) begin
                        if (avs_byteenable[k]) begin
                            control_next[8*k +: 8] = avs_writedata[8*k +: 8];
                        end
                    end
                    control_next = control_next & CONTROL_MASK;
                end
                STATUS_OFFSET: begin
                    if (avs_byteenable[0] && avs_writedata[STAT_COLLIDE_BIT]) begin
                        collide_next = 1'b0;
                    end
                end
                INIT_ADDR_OFFSET: begin
                    if (avs_byteenable[0]) begin
                        init_addr_next[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        init_addr_next[10:8] = avs_writedata[10:8];
                    end
                end
                INIT_DATA_OFFSET: begin
                    if (init_wr) begin
                        init_addr_next = init_addr_reg + 11'h001;
                    end
                end
                default: control_next = control_reg;
            endcase
        end
        if (collide_event) begin
            collide_next = 1'b1;
        end
    end

    // register file state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h0000_0000;
            control_reg <= CONTROL_RESET;
            init_addr_reg <= 11'h000;
            collide_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            readdata_reg <= readdata_next;
            control_reg <= control_next;
            init_addr_reg <= init_addr_next;
            collide_reg <= collide_next;
        end
    end

endmodule // embedded_block_ram

// >>> block_memory_pkg.sv
package block_memory_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ENTRY_COUNT = 2048;
    localparam int ENTRY_BITS = 9;
    localparam int ENTRY_IDX_BITS = 11;
    localparam int LANE_COUNT = 4;
    localparam int BYTE_BITS = 8;
    localparam int PARITY_POS = 8;
    localparam int PORT_ADDR_BITS = 14;
    localparam int PORT_DATA_BITS = 36;
    localparam logic [8:0] INIT_FILL = 9'h000;

    // ------------------------------------------------------------
    // shapes and modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {WIDTH_1, WIDTH_2, WIDTH_4, WIDTH_9, WIDTH_18, WIDTH_36} width_t;
    typedef enum logic [1:0] {MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL} mode_t;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] INIT_ADDR_OFFSET = 4'h8;
    localparam logic [3:0] INIT_DATA_OFFSET = 4'hc;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB = 0;
    localparam int MODE_FIELD_BITS = 2;
    localparam int CTL_OUTREG_A_BIT = 2;
    localparam int CTL_OUTREG_B_BIT = 3;
    localparam int CTL_PARITY_A_BIT = 4;
    localparam int CTL_PARITY_B_BIT = 5;
    localparam int CTL_INIT_BIT = 6;
    localparam int CTL_WIDTH_A_LSB = 8;
    localparam int CTL_WIDTH_B_LSB = 12;
    localparam int WIDTH_FIELD_BITS = 3;
    localparam logic [31:0] CONTROL_MASK = 32'h0000_777f;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_3300;
    localparam int STAT_SHAPE_ERR_BIT = 0;
    localparam int STAT_INIT_BIT = 1;
    localparam int STAT_COLLIDE_BIT = 2;

endpackage

// >>> block_memory_port.sv
`timescale 1ns/1ps
module block_memory_port
    import block_memory_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration
    input wire width_t width,
    input wire logic parity_en,
    input wire logic out_reg_en,
    input wire logic read_allow,
    input wire logic write_allow,
    // user request
    input wire logic req_en,
    input wire logic req_we,
    input wire logic [13:0] req_addr,
    input wire logic [35:0] req_wdata,
    input wire logic [3:0] req_byte_en,
    // user answer
    output logic [35:0] rdata,
    output logic rvalid,
    // array side
    output logic [10:0] arr_base,
    output logic [1:0] arr_lane_mask,
    output logic arr_wr,
    output logic [35:0] arr_wdata,
    output logic [35:0] arr_wmask,
    input wire logic [35:0] arr_rdata
);

    // ------------------------------------------------------------
    // input capture stage
    // ------------------------------------------------------------
    logic cap_en_reg, cap_en_next, cap_we_reg, cap_we_next;
    logic [13:0] cap_addr_reg, cap_addr_next;
    logic [35:0] cap_wdata_reg, cap_wdata_next;
    logic [3:0] cap_be_reg, cap_be_next;
    logic [35:0] rd1_reg, rd1_next, rd2_reg, rd2_next, rd_word;
    logic rd1_valid_reg, rd1_valid_next, rd2_valid_reg, rd2_valid_next;
    logic [2:0] bit_pos;
    logic [7:0] sub_mask;
    logic sub_byte;

    // refused requests never enter the pipeline
    always_comb begin
        cap_en_next = req_en & (req_we ? write_allow : read_allow);
        cap_we_next = req_we;
        cap_addr_next = req_addr;
        cap_wdata_next = req_wdata;
        cap_be_next = req_byte_en;
    end

    // ------------------------------------------------------------
    // shape decode: word index to entry and bit position
    // ------------------------------------------------------------
    always_comb begin
        arr_base = cap_addr_reg[10:0];
        arr_lane_mask = 2'h0;
        bit_pos = 3'h0;
        sub_mask = 8'h00;
        sub_byte = 1'b0;
        case (width)
            WIDTH_1: begin
                arr_base = cap_addr_reg[13:3];
                bit_pos = cap_addr_reg[2:0];
                sub_mask = 8'h01;
                sub_byte = 1'b1;
            end
            WIDTH_2: begin
                arr_base = cap_addr_reg[12:2];
                bit_pos = {cap_addr_reg[1:0], 1'b0};
                sub_mask = 8'h03;
                sub_byte = 1'b1;
            end
            WIDTH_4: begin
                arr_base = cap_addr_reg[11:1];
                bit_pos = {cap_addr_reg[0], 2'h0};
                sub_mask = 8'h0f;
                sub_byte = 1'b1;
            end
            WIDTH_9: arr_base = cap_addr_reg[10:0];
            WIDTH_18: begin
                arr_base = {cap_addr_reg[9:0], 1'b0};
                arr_lane_mask = 2'h1;
            end
            WIDTH_36: begin
                arr_base = {cap_addr_reg[8:0], 2'h0};
                arr_lane_mask = 2'h3;
            end
            default: arr_base = cap_addr_reg[10:0];
        endcase
    end

    assign arr_wr = cap_en_reg & cap_we_reg;

    // ------------------------------------------------------------
    // per-lane write data, write mask and read extraction
    // ------------------------------------------------------------
    for (genvar l = 0; l < LANE_COUNT; l++) begin : g_lane
        logic incl, be_ok;
        always_comb begin
            incl = (2'(l) & ~arr_lane_mask) == 2'h0;
            be_ok = (arr_lane_mask == 2'h0) | cap_be_reg[l];
            if (sub_byte) begin
                if (l == 0) begin
                    arr_wdata[9*l +: 9] = {1'b0, (cap_wdata_reg[7:0] & sub_mask) << bit_pos};
                    arr_wmask[9*l +: 9] = {1'b0, sub_mask << bit_pos};
                    rd_word[9*l +: 9] = {1'b0, (arr_rdata[7:0] >> bit_pos) & sub_mask};
                end else begin
                    arr_wdata[9*l +: 9] = 9'h000;
                    arr_wmask[9*l +: 9] = 9'h000;
                    rd_word[9*l +: 9] = 9'h000;
                end
            end else begin
                // parity is stored as plain data, never generated here
                arr_wdata[9*l +: 9] = cap_wdata_reg[9*l +: 9];
                arr_wmask[9*l +: 9] = {parity_en, 8'hff} & {9{incl & be_ok}};
                rd_word[9*l +: 9] = arr_rdata[9*l +: 9] & {parity_en & incl, {8{incl}}};
            end
        end
    end

    // ------------------------------------------------------------
    // read stages: array latch then optional output register
    // ------------------------------------------------------------
    // writes leave the output alone, so it shows the last read word
    always_comb begin
        rd1_valid_next = cap_en_reg & ~cap_we_reg;
        rd1_next = rd1_valid_next ? rd_word : rd1_reg;
        rd2_valid_next = rd1_valid_reg;
        rd2_next = rd1_valid_reg ? rd1_reg : rd2_reg;
    end

    assign rdata = out_reg_en ? rd2_reg : rd1_reg;
    assign rvalid = out_reg_en ? rd2_valid_reg : rd1_valid_reg;

    // registers of all three stages: input capture, array latch and output register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cap_en_reg <= 1'b0;
            cap_we_reg <= 1'b0;
            cap_addr_reg <= 14'h0;
            cap_wdata_reg <= 36'h0;
            cap_be_reg <= 4'h0;
            rd1_reg <= 36'h0;
            rd2_reg <= 36'h0;
            rd1_valid_reg <= 1'b0;
            rd2_valid_reg <= 1'b0;
        end else begin
            cap_en_reg <= cap_en_next;
            cap_we_reg <= cap_we_next;
            cap_addr_reg <= cap_addr_next;
            cap_wdata_reg <= cap_wdata_next;
            cap_be_reg <= cap_be_next;
            rd1_reg <= rd1_next;
            rd2_reg <= rd2_next;
            rd1_valid_reg <= rd1_valid_next;
            rd2_valid_reg <= rd2_valid_next;
        end
    end

endmodule // block_memory_port

// >>> embedded_block_ram_properties.sv
`timescale 1ns/1ps
module embedded_block_ram_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // user ports
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [35:0] a_rdata,
    input wire logic a_rvalid,
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [35:0] b_rdata,
    input wire logic b_rvalid
);
    // ------------------------------------------------------------
    // port timing relations
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // every access starts with exactly one wait cycle
    a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("access finished without a wait cycle");
    a_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait lasted more than one cycle");
    a_idle_nowait: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("wait raised with no access");
    // read data only moves after a read is latched
    a_readdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("register read data moved without a read");
    // a result needs a read two or three edges back
    a_rvalid_cause: assert property (a_rvalid |->
        $past(a_en && !a_we, 2) || $past(a_en && !a_we, 3))
        else $error("port a result without a matching read");
    a_b_rvalid_cause: assert property (b_rvalid |->
        $past(b_en && !b_we, 2) || $past(b_en && !b_we, 3))
        else $error("port b result without a matching read");
    // writes must leave the outputs alone
    a_rdata_quiet: assert property ($changed(a_rdata) |-> a_rvalid)
        else $error("port a data moved outside a read result");
    a_b_rdata_quiet: assert property ($changed(b_rdata) |-> b_rvalid)
        else $error("port b data moved outside a read result");
    c_a_read: cover property (a_rvalid);
    c_b_read: cover property (b_rvalid);
    c_reg_write: cover property (avs_write && !avs_waitrequest);
endmodule // embedded_block_ram_properties

// >>> fabric_port.sv
`timescale 1ns/1ps
module fabric_port (
    // clock
    input wire logic core_clk,
    // request side
    output logic en,
    output logic we,
    output logic [13:0] addr,
    output logic [35:0] wdata,
    output logic [3:0] byte_en,
    // answer side
    input wire logic [35:0] rdata,
    input wire logic rvalid
);
    // ------------------------------------------------------------
    // user logic requests, one per call
    // ------------------------------------------------------------
    initial begin
        en = 1'b0;
        we = 1'b0;
        addr = 14'h0;
        wdata = 36'h0;
        byte_en = 4'h0;
    end
    // released address and data lines are scrambled so nothing leans on stale values
    task automatic put(input logic [13:0] a, input logic [35:0] d, input logic [3:0] be);
        en <= 1'b1;
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        byte_en <= be;
        @(posedge core_clk);
        en <= 1'b0;
        we <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        @(posedge core_clk);
    endtask
    // a refused read leaves all ones, never a stored word
    task automatic get(input logic [13:0] a, output logic [35:0] d);
        en <= 1'b1;
        we <= 1'b0;
        addr <= a;
        d = '1;
        @(posedge core_clk);
        en <= 1'b0;
        addr <= ~a;
        repeat (4) begin
            @(posedge core_clk);
            if (rvalid === 1'b1) d = rdata;
        end
    endtask
endmodule // fabric_port

// >>> tb.sv
`timescale 1ns/1ps
module tb
    import block_memory_pkg::*;
;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic a_en, a_we, b_en, b_we, a_rvalid, b_rvalid;
    logic [13:0] a_addr, b_addr;
    logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata, q, w;
    logic [3:0] a_byte_en, b_byte_en;
    int n_fail = 0, num_checks = 0, cycles = 0;
    initial forever #2.5 core_clk = ~core_clk;
    embedded_block_ram DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
        .a_wdata(a_wdata), .a_byte_en(a_byte_en), .a_rdata(a_rdata), .a_rvalid(a_rvalid),
        .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_byte_en(b_byte_en),
        .b_rdata(b_rdata), .b_rvalid(b_rvalid));
    fabric_port pa (.core_clk(core_clk), .en(a_en), .we(a_we), .addr(a_addr), .wdata(a_wdata),
        .byte_en(a_byte_en), .rdata(a_rdata), .rvalid(a_rvalid));
    fabric_port pb (.core_clk(core_clk), .en(b_en), .we(b_we), .addr(b_addr), .wdata(b_wdata),
        .byte_en(b_byte_en), .rdata(b_rdata), .rvalid(b_rvalid));
    // one register access, held until the wait drops
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard, well above the couple of hundred cycles needed
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, CONTROL_OFFSET, 32'h0);
        chk({4'h0, rd}, {4'h0, CONTROL_RESET});
        bus(1'b1, 4'h1, 32'hffff_ffff);
        bus(1'b0, 4'h1, 32'h0);
        chk({4'h0, rd}, 36'h0);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_3303);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk({35'h0, rd[STAT_SHAPE_ERR_BIT]}, 36'h1);
        $display("test registers done");
        // preload in init mode, then read back with writes kept off
        bus(1'b1, CONTROL_OFFSET, 32'h0000_3350);
        bus(1'b1, INIT_ADDR_OFFSET, 32'h0);
        bus(1'b1, INIT_DATA_OFFSET, 32'h1a5);
        bus(1'b1, INIT_DATA_OFFSET, 32'h05a);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_3310);
        pa.get(14'h0, q);
        chk(q, 36'h1a5);
        pa.get(14'h1, q);
        chk(q, 36'h05a);
        $display("test rom done");
        // a writes x36, b reads x9 through its output register
        bus(1'b1, CONTROL_OFFSET, 32'h0000_353a);
        w = 36'h1_2345_6789;
        pa.put(14'h0, w, 4'hf);
        pa.put(14'h0, 36'hf_ffff_ffff, 4'h2);
        w[17:9] = 9'h1ff;
        for (int l = 0; l < 4; l++) begin
            pb.get(14'(l), q);
            chk(q, {27'h0, w[9*l +: 9]});
        end
        pa.get(14'h0, q);
        chk(q, '1);
        // b narrowed to x1, bits walk up from entry 0
        bus(1'b1, CONTROL_OFFSET, 32'h0000_053a);
        for (int k = 0; k < 16; k++) begin
            pb.get(14'(k), q);
            chk(q, {35'h0, w[9*(k/8) + k%8]});
        end
        $display("test widths done");
        // true dual x9, parity off: both write one entry, a wins and flags it
        bus(1'b1, CONTROL_OFFSET, 32'h0000_3301);
        fork
            pa.put(14'h5, 36'h1ab, 4'hf);
            pb.put(14'h5, 36'h0cd, 4'hf);
        join
        pb.get(14'h5, q);
        chk(q, 36'h0ab);
        pa.get(14'h5, q);
        chk(q, 36'h0ab);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk({35'h0, rd[STAT_COLLIDE_BIT]}, 36'h1);
        bus(1'b1, STATUS_OFFSET, 32'h4);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk({35'h0, rd[STAT_COLLIDE_BIT]}, 36'h0);
        $display("test collision done");
        wrap_up();
    end
endmodule // tb
bind embedded_block_ram embedded_block_ram_properties props (.core_clk(core_clk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .a_en(a_en), .a_we(a_we), .a_rdata(a_rdata),
    .a_rvalid(a_rvalid), .b_en(b_en), .b_we(b_we), .b_rdata(b_rdata), .b_rvalid(b_rvalid));
